//--- cbc_pkg.sv
// Overview of operation
// (RULE1) read enable high: one byte per read clock
// (RULE2) host never raises read during write
// (RULE3) write enable high: store byte every cycle
// (RULE4) write enable synchronised before use
// (RULE5) host keeps read clock free running
// (RULE6) output data, empty flag follow read clock
// (RULE7) reset returns pointers and flags to initial
// (RULE8) synchronised write enable driven out
// (RULE9) out-of-range sticks high during capture
// (RULE10) out-of-range clears after readout or reset
// (RULE11) full flag when all locations unread
// (RULE12) no auto stop: pointer wraps, overwrites
// (RULE13) full drops when read starts or reset
// (RULE14) empty flag when nothing unread remains
// (RULE15) empty clears once data has been written
// (RULE16) dual port: two samples, earlier on port2
// (RULE17) read idle: port1 holds last byte
// (RULE18) each port has aligned data-ready strobe
// (RULE19) auto stop: writes halt when full
// (RULE20) flags from consistent pointer state, no glitches
`default_nettype none
package cbc_pkg;
  localparam int CBC_DEPTH = 4096;
  localparam int CBC_DATA_W = 8;
  localparam int CBC_SYNC_STAGES = 3;
  // register byte offsets
  localparam logic [3:0] CBC_OFS_CTRL = 4'h0;
  localparam logic [3:0] CBC_OFS_STATUS = 4'h4;
  // control fields
  localparam int CBC_CTRL_ASW_BIT = 0;
  localparam int CBC_CTRL_DUAL_BIT = 1;
  localparam logic [1:0] CBC_CTRL_RESET = 2'h0;
  // status fields
  localparam int CBC_ST_FULL_BIT = 0;
  localparam int CBC_ST_EMPTY_BIT = 1;
  localparam int CBC_ST_OOR_BIT = 2;
  localparam int CBC_ST_WSYNC_BIT = 3;
  localparam int CBC_ST_LEVEL_LSB = 16;
endpackage
`default_nettype wire

//--- cbc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_sync (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic async_in, // pin level
  output logic level_q // filtered level
);
  import cbc_pkg::*;
  logic [CBC_SYNC_STAGES-1:0] stage_q;
  wire agree = (stage_q[1] == stage_q[2]);

  // stage 0 only feeds stage 1; the filter looks at stages 1 and 2
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
      level_q <= 1'b0;
    end else begin
      stage_q <= {stage_q[1:0], async_in};
      if (agree) begin
        level_q <= stage_q[2];
      end
    end
  end
endmodule
`default_nettype wire

//--- cbc_capture_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_capture_buffer
  import cbc_pkg::*;
#(
  parameter int DEPTH = CBC_DEPTH,
  parameter int DW = CBC_DATA_W
) (
  input wire logic clk_sys, // sample clock, 200 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic buf_reset, // buffer reset pin, active high
  input wire logic write_enable, // write enable pin, async
  input wire logic read_enable, // read enable pin
  input wire logic read_clock, // read clock pin
  input wire logic [DW-1:0] conv_data, // converter sample
  input wire logic conv_out_of_range, // converter range flag
  output logic [DW-1:0] port1_data, // data port 1
  output logic [DW-1:0] port2_data, // data port 2
  output logic port2_oe, // port 2 drive enable
  output logic output_valid_strobe1, // port 1 data ready
  output logic output_valid_strobe2, // port 2 data ready
  output logic buffer_full_flag, // all locations unread
  output logic buffer_empty_flag, // nothing unread
  output logic out_of_range, // sticky range flag
  output logic write_strobe_synced, // synchronised write enable
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest // stall
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p,
                                             input logic [1:0] n);
    ptr_add = p + AW'(n);
  endfunction

  logic wen_lvl, ren_lvl, rclk_lvl, brst_lvl;
  logic rclk_prev_q;
  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [CW-1:0] count_q;
  logic [1:0] ctrl_q;
  logic acc_q;

  // write enable is a pin: filtered before any write acts on it
  cbc_sync u_wen ( // RULE4
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(write_enable),
    .level_q(wen_lvl)
  );
  cbc_sync u_ren (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(read_enable),
    .level_q(ren_lvl)
  );
  cbc_sync u_rclk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(read_clock),
    .level_q(rclk_lvl)
  );
  cbc_sync u_brst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(buf_reset),
    .level_q(brst_lvl)
  );

  wire auto_stop_write = ctrl_q[CBC_CTRL_ASW_BIT];
  wire dual = ctrl_q[CBC_CTRL_DUAL_BIT];
  wire is_full = (count_q == FULL_CNT);
  wire is_empty = (count_q == '0);
  wire rclk_rise = rclk_lvl & ~rclk_prev_q;
  // a half-filled pair is left until a second sample arrives
  wire rd_go = rclk_rise & ren_lvl
             & (dual ? (count_q >= CW'(2)) : !is_empty); // RULE1
  wire [1:0] rd_n = rd_go ? (dual ? 2'd2 : 2'd1) : 2'd0;
  wire wr_go = wen_lvl & !(is_full & auto_stop_write); // RULE3 RULE19
  // overwrite drags the read pointer along with the write
  wire ovw = wr_go & is_full & !rd_go; // RULE12
  wire [CW-1:0] count_d = count_q + CW'(wr_go) - CW'(rd_n) - CW'(ovw);
  wire [AW-1:0] rp_d = ptr_add(rp_q, rd_n + {1'b0, ovw});
  wire [AW-1:0] rp_next = ptr_add(rp_q, 2'd1);
  wire oor_clr = rd_go & (count_d == '0); // RULE10
  wire oor_set = wr_go & conv_out_of_range; // RULE9

  // bus decode
  wire bus_req = avs_read | avs_write;
  wire bus_done = bus_req & acc_q;
  wire sel_ctrl = (avs_address == CBC_OFS_CTRL);
  wire sel_stat = (avs_address == CBC_OFS_STATUS);
  wire ctrl_we = bus_done & avs_write & sel_ctrl & avs_byteenable[0];
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[CBC_ST_FULL_BIT] = buffer_full_flag;
    status_word[CBC_ST_EMPTY_BIT] = buffer_empty_flag;
    status_word[CBC_ST_OOR_BIT] = out_of_range;
    status_word[CBC_ST_WSYNC_BIT] = write_strobe_synced;
    status_word[CBC_ST_LEVEL_LSB +: CW] = count_q;
  end
  wire [31:0] rd_word = sel_ctrl ? {30'h0, ctrl_q} :
                        sel_stat ? status_word : 32'h0000_0000;

  // storage carries no reset; pointers define what is valid
  always_ff @(posedge clk_sys) begin
    if (wr_go) begin
      mem_q[wp_q] <= conv_data; // RULE3
    end
  end

  // pointers and level share one clock, so flags derive from one
  // consistent count and cannot glitch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
    end else if (brst_lvl) begin
      wp_q <= '0; // RULE7
      rp_q <= '0;
      count_q <= '0;
    end else begin
      if (wr_go) begin
        wp_q <= ptr_add(wp_q, 2'd1); // RULE12
      end
      rp_q <= rp_d;
      count_q <= count_d; // RULE20
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buffer_full_flag <= 1'b0;
      buffer_empty_flag <= 1'b1;
      out_of_range <= 1'b0;
      write_strobe_synced <= 1'b0;
    end else if (brst_lvl) begin
      buffer_full_flag <= 1'b0; // RULE7 RULE13
      buffer_empty_flag <= 1'b1;
      out_of_range <= 1'b0; // RULE10
      write_strobe_synced <= wen_lvl;
    end else begin
      buffer_full_flag <= (count_d == FULL_CNT); // RULE11 RULE13
      // set only on a read clock rise, but a write clears it at once
      // so full and empty can never stand together
      if (rclk_rise) begin
        buffer_empty_flag <= (count_d == '0); // RULE6 RULE14
      end else if (count_d != '0) begin
        buffer_empty_flag <= 1'b0; // RULE15
      end
      if (oor_set) begin
        out_of_range <= 1'b1; // RULE9
      end else if (oor_clr) begin
        out_of_range <= 1'b0; // RULE10
      end
      write_strobe_synced <= wen_lvl; // RULE8
    end
  end

  // data ports change only on a read clock edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rclk_prev_q <= 1'b0;
      port1_data <= '0;
      port2_data <= '0;
      port2_oe <= 1'b0;
      output_valid_strobe1 <= 1'b0;
      output_valid_strobe2 <= 1'b0;
    end else begin
      rclk_prev_q <= rclk_lvl;
      port2_oe <= dual; // RULE16
      output_valid_strobe1 <= rclk_lvl; // RULE18
      output_valid_strobe2 <= rclk_lvl & dual; // RULE18
      if (rd_go && dual) begin
        port2_data <= mem_q[rp_q]; // RULE16
        port1_data <= mem_q[rp_next];
      end else if (rd_go) begin
        port1_data <= mem_q[rp_q]; // RULE1 RULE6
      end
      // otherwise ports hold the last read byte
    end // RULE17
  end

  // one wait cycle per access: answer on the second cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      ctrl_q <= CBC_CTRL_RESET;
    end else begin
      acc_q <= bus_req & !acc_q;
      avs_waitrequest <= !(bus_req & !acc_q);
      if (bus_req && !acc_q) begin
        avs_readdata <= avs_read ? rd_word : 32'h0000_0000;
      end
      if (ctrl_we) begin
        ctrl_q <= avs_writedata[1:0];
      end
    end
  end
endmodule
`default_nettype wire

//--- cbc_capture_buffer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_capture_buffer_checker (
  input wire logic clk_sys, // sample clock
  input wire logic rst_n, // reset, active low
  input wire logic buf_reset, write_enable, read_enable, // pins
  input wire logic avs_read, avs_write, avs_waitrequest, // bus
  input wire logic port2_oe, output_valid_strobe2, // port 2
  input wire logic buffer_full_flag, buffer_empty_flag, // levels
  input wire logic out_of_range, write_strobe_synced // status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  // pin filters take a few cycles, so hold inputs long enough
  sequence s_clear;
    buf_reset [*6];
  endsequence
  a_req_wait: assert property (s_req |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  a_flags_apart: assert property (!(buffer_full_flag && buffer_empty_flag))
    else $error("full and empty together");
  a_port2_quiet: assert property (!port2_oe |-> !output_valid_strobe2)
    else $error("port 2 strobe while off");
  a_reset_clears: assert property (s_clear |->
    buffer_empty_flag && !buffer_full_flag && !out_of_range)
    else $error("buffer reset left state");
  a_wsync_high: assert property (write_enable [*6] |-> write_strobe_synced)
    else $error("synced write enable low");
  a_wsync_low: assert property (!write_enable [*6] |-> !write_strobe_synced)
    else $error("synced write enable high");
  a_range_hold: assert property ((out_of_range && !read_enable
    && !buf_reset) [*5] |=> out_of_range)
    else $error("range flag dropped");
endmodule
`default_nettype wire

//--- cbc_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_reader_model (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic write_enable, // write pin level
  input wire logic read_go, // bench wants a readout
  output logic read_clock, // read clock
  output logic read_enable // read pin
);
  // never gated; slower than a quarter of clk_sys for the filter
  initial begin
    read_clock = 1'b0;
    forever #20 read_clock = ~read_clock;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) read_enable <= 1'b0;
    else read_enable <= read_go && (read_enable || !write_enable);
  end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cbc_pkg::*;
  logic clk_sys, rst_n, buf_reset, write_enable, read_go;
  logic conv_out_of_range, avs_read, avs_write, read_enable, read_clock;
  logic port2_oe, output_valid_strobe1, output_valid_strobe2;
  logic buffer_full_flag, buffer_empty_flag, out_of_range;
  logic write_strobe_synced, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [7:0] conv_data, port1_data, port2_data, base, f1, f2;
  logic [31:0] avs_writedata, avs_readdata, q;
  int mismatches, num_checks, cyc, cnt;
  cbc_capture_buffer #(.DEPTH(8)) uut (.*);
  cbc_reader_model partner (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    conv_data <= conv_data + 8'h01;
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      test_done;
    end
  end
  task test_done;
    $display("mismatches %0d checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // bytes stored follow the free counter, so order is checkable
  task burst(input int n, input logic r);
    @(posedge clk_sys);
    write_enable <= 1'b1;
    conv_out_of_range <= r;
    #1 base = conv_data;
    repeat (n) @(posedge clk_sys);
    write_enable <= 1'b0;
    conv_out_of_range <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
  task rdall(output int c, output logic [7:0] f);
    logic sp;
    logic [7:0] lp;
    c = 0;
    sp = 1'b1;
    lp = port1_data;
    read_go <= 1'b1;
    while (!(c > 0 && buffer_empty_flag === 1'b1)) begin
      @(posedge clk_sys);
      #1;
      if (output_valid_strobe1 && !sp && port1_data !== lp) begin
        if (c == 0) f = port1_data;
        else chk(port1_data, 8'(lp + (port2_oe ? 2 : 1)));
        if (port2_oe) chk(port2_data, 8'(port1_data - 1));
        c++;
        lp = port1_data;
      end
      sp = output_valid_strobe1;
    end
    @(posedge clk_sys);
    read_go <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(port1_data, lp);
  endtask
  initial begin
    {rst_n, buf_reset, write_enable, read_go, conv_out_of_range} = 5'h00;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    conv_data = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    bus(1'b0, CBC_OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    burst(11, 1'b1);
    bus(1'b0, CBC_OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0008_0005);
    rdall(cnt, f1);
    f1 = f1 - base;
    chk(cnt, 8);
    chk({buffer_full_flag, buffer_empty_flag, out_of_range}, 3'h2);
    bus(1'b1, CBC_OFS_CTRL, 32'h0000_0001);
    bus(1'b0, CBC_OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    burst(11, 1'b0);
    rdall(cnt, f2);
    f2 = f2 - base;
    chk(8'(f1 - f2), 8'h03);
    bus(1'b1, CBC_OFS_CTRL, 32'h0000_0002);
    burst(4, 1'b0);
    rdall(cnt, f2);
    chk(cnt, 2);
    burst(3, 1'b0);
    buf_reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    buf_reset <= 1'b0;
    bus(1'b0, CBC_OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    test_done;
  end
endmodule
bind cbc_capture_buffer cbc_capture_buffer_checker chk_i (.*);
`default_nettype wire
